/* logic/stc_map.svh */
// Constant map of the stepper translator and chopper block.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register port.
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
// ==========================================================================
`define STC_OFS_CHOP_PERIOD 32'h0000_0000
`define STC_OFS_PEAK_REF 32'h0000_0004
`define STC_OFS_STATUS 32'h0000_0008

// ==========================================================================
// Field positions of the status register
// ==========================================================================
`define STC_ST_STATE_LSB 0
`define STC_ST_STATE_MSB 2
`define STC_ST_HOME 3
`define STC_ST_LATCH_AB 4
`define STC_ST_LATCH_CD 5
`define STC_ST_MODE_LSB 6
`define STC_ST_MODE_MSB 7
`define STC_ST_ENABLE 8
`define STC_ST_DIR 9
`define STC_ST_OWN_OSC 10

// ==========================================================================
// Timing and reset values
// ==========================================================================
`define STC_CLK_MHZ 25
`define STC_CHOP_PERIOD_NS 50000
`define STC_CHOP_PERIOD_CYC ((`STC_CHOP_PERIOD_NS * `STC_CLK_MHZ) / 1000)
`define STC_PEAK_REF_RST 8'h80
`define STC_HOME_PHASE 4'h5
`define STC_HOME_STATE 3'h0

`endif

/* logic/stc_pkg.sv */
// Types shared by the stepper translator and chopper block.
// Assumes the constant map is included wherever numbers are needed.
package stc_pkg;

    // ======================================================================
    // Drive modes of the translator
    // ======================================================================
    // Half step, one-phase-on and two-phase-on full step.
    typedef enum logic [1:0] {
        STC_HALF,
        STC_WAVE,
        STC_NORMAL
    } stc_mode_t;

    // ======================================================================
    // Bundles that travel together
    // ======================================================================
    // Everything presented to the power bridge in one cycle.
    typedef struct packed {
        logic [3:0] phase;
        logic inh_ab_n;
        logic inh_cd_n;
    } stc_drive_t;

    // Pin levels after the synchroniser, in one group.
    typedef struct packed {
        logic step_n;
        logic reset_n;
        logic enable;
        logic dir_cw;
        logic half_sel;
        logic chop_phase;
        logic osc_gnd;
        logic sync_in;
    } stc_pins_t;

endpackage

/* logic/stc_sync.sv */
// Two-flop synchroniser for levels that come from outside the clock domain.
// Assumes independent bits; a multi-bit word may skew.
`timescale 1ns/10ps

module stc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage; only the second stage looks at it.
    logic [W-1:0] meta_reg;

    // ======================================================================
    // Both stages
    // ======================================================================
    // Two flops settle any metastability before logic reads the level.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // stc_sync

/* logic/stc_top.sv */
// Stepper translator with dual chopper and an AHB-Lite register port.
// Assumes host pins arrive asynchronously and sense words come from ADCs.
`timescale 1ns/10ps
`include "stc_map.svh"

module stc_top #(
    parameter int SENSE_W = 8,
    parameter int PERIOD_W = 16
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // AHB-Lite slave port.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // Host control pins.
    input wire logic STEP_CLK_N,
    input wire logic RESET_N,
    input wire logic ENABLE,
    input wire logic ROTATION_DIR,
    input wire logic STEP_SIZE_SELECT,
    input wire logic CHOP_TARGET_SELECT,
    input wire logic OSC_RC_NODE_GROUNDED,
    // Current sense words from the two pairs.
    input wire logic [SENSE_W-1:0] SENSE_AB,
    input wire logic [SENSE_W-1:0] SENSE_CD,
    // Chopper sync two-way pin.
    input wire logic CHOP_SYNC_I,
    output logic CHOP_SYNC_O,
    output logic CHOP_SYNC_OE_N,
    // Power bridge drive.
    output logic PHASE_W,
    output logic PHASE_X,
    output logic PHASE_Y,
    output logic PHASE_Z,
    output logic PAIR_AB_INHIBIT_N,
    output logic PAIR_CD_INHIBIT_N,
    output logic INITIAL_POSITION_FLAG_PULL
);

    // ======================================================================
    // Helper functions
    // ======================================================================
    // Phase pattern w,x,y,z of a translator index (index 0 is state 1).
    function automatic logic [3:0] phase_of(input logic [2:0] idx);
        logic [3:0] p;
        p = 4'h5;
        case (idx)
            3'd0: p = 4'h5;
            3'd1: p = 4'h1;
            3'd2: p = 4'h9;
            3'd3: p = 4'h8;
            3'd4: p = 4'hA;
            3'd5: p = 4'h2;
            3'd6: p = 4'h6;
            3'd7: p = 4'h4;
            default: p = 4'h5;
        endcase
        return p;
    endfunction

    // Word index of a byte address, used for decode and write-forwarding.
    function automatic logic [29:0] word_of(input logic [31:0] a);
        return a[31:2];
    endfunction

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Every host pin and the sync pin pass two flops before use.
    stc_pkg::stc_pins_t pins_raw;
    stc_pkg::stc_pins_t pins;
    logic [SENSE_W-1:0] sense_ab;
    logic [SENSE_W-1:0] sense_cd;

    assign pins_raw = '{step_n: STEP_CLK_N, reset_n: RESET_N, enable: ENABLE,
                        dir_cw: ROTATION_DIR, half_sel: STEP_SIZE_SELECT,
                        chop_phase: CHOP_TARGET_SELECT,
                        osc_gnd: OSC_RC_NODE_GROUNDED, sync_in: CHOP_SYNC_I};

    // The direction level is synchronised here like every other pin.
    stc_sync #(.W($bits(stc_pkg::stc_pins_t))) u_sync_pins (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .d(pins_raw),
        .q(pins)
    );

    // Sense words may skew for a cycle; the chopper tolerates it.
    stc_sync #(.W(2 * SENSE_W)) u_sync_sense (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .d({SENSE_AB, SENSE_CD}),
        .q({sense_ab, sense_cd})
    );

    // ======================================================================
    // Registers visible to software
    // ======================================================================
    logic [PERIOD_W-1:0] chop_period_reg; // Own oscillator period in cycles.
    logic [SENSE_W-1:0] peak_ref_reg; // Peak current threshold.
    logic [2:0] state_reg; // Translator index, 0 is the home state.
    logic chop_latch_ab_reg; // Drive permit of the first pair.
    logic chop_latch_cd_reg; // Drive permit of the second pair.
    stc_pkg::stc_mode_t mode; // Current translator mode.

    // ======================================================================
    // AHB-Lite slave
    // ======================================================================
    // Zero wait states: read data is fetched at the address phase edge.
    logic addr_ok; // A valid transfer is offered this cycle.
    logic wr_pend_reg; // A write is in its data phase.
    logic [29:0] wr_word_reg; // Word index of that write.
    logic [31:0] status_word; // Live status image.
    logic [31:0] rd_next; // Read data chosen for the next data phase.

    assign addr_ok = HSEL & HTRANS[1] & HREADY;

    // Status image of the block's state.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STC_ST_STATE_MSB:`STC_ST_STATE_LSB] = state_reg;
        status_word[`STC_ST_HOME] = (state_reg == `STC_HOME_STATE);
        status_word[`STC_ST_LATCH_AB] = chop_latch_ab_reg;
        status_word[`STC_ST_LATCH_CD] = chop_latch_cd_reg;
        status_word[`STC_ST_MODE_MSB:`STC_ST_MODE_LSB] = mode;
        status_word[`STC_ST_ENABLE] = pins.enable;
        status_word[`STC_ST_DIR] = pins.dir_cw;
        status_word[`STC_ST_OWN_OSC] = ~pins.osc_gnd;
    end

    // Read mux; a write still in flight to the same word is forwarded,
    // because its register only updates at this very edge.
    always_comb begin
        rd_next = 32'h0000_0000;
        if (word_of(HADDR) == word_of(`STC_OFS_CHOP_PERIOD)) begin
            rd_next[PERIOD_W-1:0] = chop_period_reg;
            if (wr_pend_reg && wr_word_reg == word_of(HADDR)) begin
                rd_next[PERIOD_W-1:0] = HWDATA[PERIOD_W-1:0];
            end
        end else if (word_of(HADDR) == word_of(`STC_OFS_PEAK_REF)) begin
            rd_next[SENSE_W-1:0] = peak_ref_reg;
            if (wr_pend_reg && wr_word_reg == word_of(HADDR)) begin
                rd_next[SENSE_W-1:0] = HWDATA[SENSE_W-1:0];
            end
        end else if (word_of(HADDR) == word_of(`STC_OFS_STATUS)) begin
            rd_next = status_word;
        end else begin
            rd_next = 32'h0000_0000; // Unmapped words read as zero.
        end
    end

    // Bus handshake and read data; the answer is always OKAY.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_word_reg <= '0;
        end else if (CE) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend_reg <= addr_ok & HWRITE;
            if (addr_ok) begin
                wr_word_reg <= word_of(HADDR);
                if (!HWRITE) begin
                    HRDATA <= rd_next;
                end
            end
        end
    end

    // Writable registers take data in the write's data phase.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            chop_period_reg <= PERIOD_W'(`STC_CHOP_PERIOD_CYC);
            peak_ref_reg <= SENSE_W'(`STC_PEAK_REF_RST);
        end else if (CE && wr_pend_reg) begin
            if (wr_word_reg == word_of(`STC_OFS_CHOP_PERIOD)) begin
                chop_period_reg <= HWDATA[PERIOD_W-1:0];
            end
            if (wr_word_reg == word_of(`STC_OFS_PEAK_REF)) begin
                peak_ref_reg <= HWDATA[SENSE_W-1:0];
            end
        end
    end

    // ======================================================================
    // Translator
    // ======================================================================
    logic step_prev_reg; // Previous synchronised step level.
    logic step_rise; // Rising edge of the step pulse.
    logic [2:0] step_size; // One state in half step, two in full step.
    logic [2:0] state_next;

    assign step_rise = pins.step_n & ~step_prev_reg;

    // Mode follows the select level and the parity of the current state.
    always_comb begin
        if (pins.half_sel) begin
            mode = stc_pkg::STC_HALF;
        end else if (state_reg[0]) begin
            mode = stc_pkg::STC_WAVE;
        end else begin
            mode = stc_pkg::STC_NORMAL;
        end
    end

    // Full step moves by two and so never leaves its parity.
    always_comb begin
        step_size = (mode == stc_pkg::STC_HALF) ? 3'd1 : 3'd2;
        if (pins.dir_cw) begin
            state_next = 3'(state_reg + step_size);
        end else begin
            state_next = 3'(state_reg - step_size);
        end
    end

    // Edge detector; reset low holds it high, so no false edge follows reset.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            step_prev_reg <= 1'b1;
        end else if (CE) begin
            step_prev_reg <= pins.step_n | ~pins.reset_n;
        end
    end

    // Host reset wins over a step arriving in the same cycle.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= `STC_HOME_STATE;
        end else if (CE) begin
            if (!pins.reset_n) begin
                state_reg <= `STC_HOME_STATE;
            end else if (step_rise) begin
                state_reg <= state_next;
            end
        end
    end

    // ======================================================================
    // Chopper timebase
    // ======================================================================
    logic [PERIOD_W-1:0] osc_cnt_reg; // Own oscillator counter.
    logic own_tick; // Period end of the own oscillator.
    logic sync_prev_reg; // Previous settled sync level.
    logic chop_tick; // Tick that restarts both chopper channels.

    assign own_tick = (osc_cnt_reg == '0);

    // With the oscillator node grounded the shared line gives the ticks.
    assign chop_tick = pins.osc_gnd ? (pins.sync_in & ~sync_prev_reg)
                                    : own_tick;

    // Down counter reloaded from software; period zero ticks each cycle.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            osc_cnt_reg <= '0;
            sync_prev_reg <= 1'b0;
        end else if (CE) begin
            sync_prev_reg <= pins.sync_in;
            if (own_tick) begin
                osc_cnt_reg <= 
                    (chop_period_reg == '0) ? '0 : PERIOD_W'(chop_period_reg - 1'b1);
            end else begin
                osc_cnt_reg <= PERIOD_W'(osc_cnt_reg - 1'b1);
            end
        end
    end

    // The device with its own oscillator drives each tick onto the sync pin;
    // the others release the pin and listen.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CHOP_SYNC_O <= 1'b0;
            CHOP_SYNC_OE_N <= 1'b1;
        end else if (CE) begin
            CHOP_SYNC_O <= own_tick & ~pins.osc_gnd;
            CHOP_SYNC_OE_N <= pins.osc_gnd;
        end
    end

    // ======================================================================
    // Chopper channels
    // ======================================================================
    logic trip_ab; // First pair current at peak.
    logic trip_cd; // Second pair current at peak.

    assign trip_ab = (sense_ab >= peak_ref_reg);
    assign trip_cd = (sense_cd >= peak_ref_reg);

    // Each channel has its own latch; a tick beats a trip in the same
    // cycle, and a lasting trip clears the latch again one cycle later.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            chop_latch_ab_reg <= 1'b1;
            chop_latch_cd_reg <= 1'b1;
        end else if (CE) begin
            if (chop_tick) begin
                chop_latch_ab_reg <= 1'b1;
                chop_latch_cd_reg <= 1'b1;
            end else begin
                if (trip_ab) begin
                    chop_latch_ab_reg <= 1'b0;
                end
                if (trip_cd) begin
                    chop_latch_cd_reg <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Output stage
    // ======================================================================
    stc_pkg::stc_drive_t drive; // Pattern before enable gating.
    logic [3:0] base_phase;

    // Inhibits follow pair activity; chopping then acts on one target.
    always_comb begin
        base_phase = phase_of(state_reg);
        drive.phase = base_phase;
        // A dead pair is inhibited; in normal mode both pairs stay live.
        drive.inh_ab_n = |base_phase[3:2];
        drive.inh_cd_n = |base_phase[1:0];
        if (!pins.chop_phase) begin
            drive.inh_ab_n = drive.inh_ab_n & chop_latch_ab_reg;
            drive.inh_cd_n = drive.inh_cd_n & chop_latch_cd_reg;
        end else begin
            // Raising the idle line keeps sense-resistor dissipation down.
            if (!chop_latch_ab_reg && |base_phase[3:2]) begin
                drive.phase[3:2] = 2'b11;
            end
            if (!chop_latch_cd_reg && |base_phase[1:0]) begin
                drive.phase[1:0] = 2'b11;
            end
        end
    end

    // Registered pins; enable low pulls all six drive lines low.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            {PHASE_W, PHASE_X, PHASE_Y, PHASE_Z} <= 4'h0;
            PAIR_AB_INHIBIT_N <= 1'b0;
            PAIR_CD_INHIBIT_N <= 1'b0;
        end else if (CE) begin
            if (!pins.enable) begin
                {PHASE_W, PHASE_X, PHASE_Y, PHASE_Z} <= 4'h0;
                PAIR_AB_INHIBIT_N <= 1'b0;
                PAIR_CD_INHIBIT_N <= 1'b0;
            end else begin
                {PHASE_W, PHASE_X, PHASE_Y, PHASE_Z} <= drive.phase;
                PAIR_AB_INHIBIT_N <= drive.inh_ab_n;
                PAIR_CD_INHIBIT_N <= drive.inh_cd_n;
            end
        end
    end

    // Open-collector home flag: the transistor is off at the home state.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            INITIAL_POSITION_FLAG_PULL <= 1'b0;
        end else if (CE) begin
            INITIAL_POSITION_FLAG_PULL <= (phase_of(state_reg) != `STC_HOME_PHASE);
        end
    end

endmodule // stc_top

/* sim/stc_monitor.sv */
// Checker of the pins of stc_top.
// Assumes CE high; bound from the bench top file.
`timescale 1ns/10ps

module stc_monitor #(
    parameter int SENSE_W = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic ENABLE,
    input wire logic CHOP_TARGET_SELECT,
    input wire logic OSC_RC_NODE_GROUNDED,
    input wire logic [SENSE_W-1:0] SENSE_AB,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic CHOP_SYNC_O,
    input wire logic CHOP_SYNC_OE_N,
    input wire logic PHASE_W,
    input wire logic PHASE_X,
    input wire logic PHASE_Y,
    input wire logic PHASE_Z,
    input wire logic PAIR_AB_INHIBIT_N,
    input wire logic PAIR_CD_INHIBIT_N,
    input wire logic INITIAL_POSITION_FLAG_PULL
);
    // ==========================================================================
    // Sequences
    // ==========================================================================
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // Enable low long enough to reach the pins.
    sequence s_drive_off;
        !ENABLE [*4];
    endsequence

    // Steady first pair overcurrent, inhibits chopped.
    sequence s_ab_trip;
        (SENSE_AB == '1 && !CHOP_TARGET_SELECT && ENABLE) [*6];
    endsequence

    // ==========================================================================
    // Assertions
    // ==========================================================================
    a_home_flag_off: assert property (
        {PHASE_W, PHASE_X, PHASE_Y, PHASE_Z} == 4'h5 |-> !INITIAL_POSITION_FLAG_PULL)
        else $error("home flag on at home");
    a_ab_dead_low: assert property (
        !PHASE_W && !PHASE_X |-> !PAIR_AB_INHIBIT_N)
        else $error("pair ab inhibit high while dead");
    a_cd_dead_low: assert property (
        !PHASE_Y && !PHASE_Z |-> !PAIR_CD_INHIBIT_N)
        else $error("pair cd inhibit high while dead");
    a_enable_forces_low: assert property (
        s_drive_off |-> {PHASE_W, PHASE_X, PHASE_Y, PHASE_Z,
                         PAIR_AB_INHIBIT_N, PAIR_CD_INHIBIT_N} == 6'h00)
        else $error("drive not low while disabled");
    a_own_osc_drives: assert property (
        !OSC_RC_NODE_GROUNDED [*4] |-> !CHOP_SYNC_OE_N)
        else $error("sync pin not driven");
    a_slave_osc_release: assert property (
        OSC_RC_NODE_GROUNDED [*4] |-> CHOP_SYNC_OE_N)
        else $error("sync pin driven as listener");
    a_tick_one_cycle: assert property (
        CHOP_SYNC_O |=> !CHOP_SYNC_O [*6])
        else $error("sync tick too long");
    a_ab_trip_chops: assert property (
        s_ab_trip ##0 PAIR_AB_INHIBIT_N |-> ##[1:2] !PAIR_AB_INHIBIT_N)
        else $error("trip did not end ab drive");
    a_bus_okay_ready: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or not okay");

    c_trip_seen: cover property (s_ab_trip ##0 PAIR_AB_INHIBIT_N);
endmodule // stc_monitor

/* sim/stc_host_model.sv */
// Host model: step pulses, translator reset, direction, step size.
// Assumes the clock of the block; all pins change right after a rising edge.
`timescale 1ns/10ps

module stc_host_model (
    input wire logic clk,
    output logic step_clk_n,
    output logic reset_n,
    output logic rotation_dir,
    output logic step_size_select
);
    // Idle levels: no step, no reset, forward, half step.
    initial begin
        step_clk_n = 1'b1;
        reset_n = 1'b1;
        rotation_dir = 1'b1;
        step_size_select = 1'b1;
    end

    // One increment; three cycles low so the synchroniser keeps it.
    task automatic step();
        @(posedge clk);
        step_clk_n <= 1'b0;
        repeat (3) @(posedge clk);
        step_clk_n <= 1'b1;
        repeat (7) @(posedge clk);
    endtask

    // Translator reset pulse, then settling room.
    task automatic reset_pulse();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (7) @(posedge clk);
    endtask

    // Direction and step size may change at any time.
    task automatic mode(input logic dir, input logic half);
        @(posedge clk);
        rotation_dir <= dir;
        step_size_select <= half;
        repeat (4) @(posedge clk);
    endtask
endmodule // stc_host_model

/* sim/stepper_translator_chopper_tb.sv */
// Self-checking bench of stc_top: bus registers, translator and chopper.
// Assumes the host model drives the step pins, the bench the rest.
`timescale 1ns/10ps
`include "stc_map.svh"

module stepper_translator_chopper_tb;
    localparam logic [3:0] PAT [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic enable = 1'b0;
    logic chop_tgt = 1'b0;
    logic osc_gnd = 1'b0;
    logic sync_in = 1'b0;
    logic [7:0] sense_ab = 8'h00;
    logic [7:0] sense_cd = 8'h00;
    logic hreadyout, hresp, sync_o, sync_oe_n, flag_pull, inh_ab_n, inh_cd_n;
    logic step_n, tr_reset_n, dir, half;
    logic [31:0] hrdata;
    logic [3:0] ph;
    int n_fail = 0;
    int n_checks = 0;
    int cnt_a;
    int cnt_b;

    always #20 clk = ~clk;

    stc_host_model host (.clk(clk), .step_clk_n(step_n), .reset_n(tr_reset_n),
        .rotation_dir(dir), .step_size_select(half));

    // Sync wire: the block drives it while CHOP_SYNC_OE_N is low, else the bench.
    stc_top dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
        .HRDATA(hrdata), .STEP_CLK_N(step_n), .RESET_N(tr_reset_n), .ENABLE(enable),
        .ROTATION_DIR(dir), .STEP_SIZE_SELECT(half), .CHOP_TARGET_SELECT(chop_tgt),
        .OSC_RC_NODE_GROUNDED(osc_gnd), .SENSE_AB(sense_ab), .SENSE_CD(sense_cd),
        .CHOP_SYNC_I(sync_oe_n ? sync_in : sync_o), .CHOP_SYNC_O(sync_o),
        .CHOP_SYNC_OE_N(sync_oe_n), .PHASE_W(ph[3]), .PHASE_X(ph[2]), .PHASE_Y(ph[1]),
        .PHASE_Z(ph[0]), .PAIR_AB_INHIBIT_N(inh_ab_n), .PAIR_CD_INHIBIT_N(inh_cd_n),
        .INITIAL_POSITION_FLAG_PULL(flag_pull));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One word transfer; waits on hready, never on a count.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, q, e);
    endtask

    // Counts first pair chopped and second pair free cycles.
    task automatic watch(input int n);
        cnt_a = 0;
        cnt_b = 0;
        repeat (n) begin
            @(posedge clk);
            if ((chop_tgt ? (ph[3:2] === 2'b11) : (inh_ab_n === 1'b0))) cnt_a++;
            if (inh_cd_n === 1'b1 && ph[1:0] === 2'b01) cnt_b++;
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        logic [31:0] q;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`STC_OFS_CHOP_PERIOD, 32'h0000_04E2, "period_reset");
        rd_chk(`STC_OFS_PEAK_REF, 32'h0000_0080, "peak_ref_reset");
        bus(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, q);
        rd_chk(32'h0000_000C, 32'h0000_0000, "unmapped");
        bus(1'b1, `STC_OFS_CHOP_PERIOD, 32'h0000_0008, q);
        rd_chk(`STC_OFS_CHOP_PERIOD, 32'h0000_0008, "period");
        enable <= 1'b1;
        repeat (5) @(posedge clk);
        chk("home", ph, PAT[0]);
        chk("home_flag", flag_pull, 1'b0);
        for (int i = 1; i <= 8; i++) begin
            host.step();
            chk("half_fwd", ph, PAT[i % 8]);
            chk("flag", flag_pull, (i % 8) != 0);
        end
        host.mode(1'b0, 1'b1);
        host.step();
        chk("half_rev", ph, PAT[7]);
        host.mode(1'b1, 1'b1);
        host.step();
        host.mode(1'b1, 1'b0);
        host.step();
        chk("normal", ph, PAT[2]);
        chk("normal_inh", {inh_ab_n, inh_cd_n}, 2'b11);
        host.step();
        chk("normal2", ph, PAT[4]);
        host.reset_pulse();
        chk("tr_reset", ph, PAT[0]);
        host.mode(1'b1, 1'b1);
        host.step();
        host.mode(1'b1, 1'b0);
        host.step();
        chk("wave", ph, PAT[3]);
        chk("wave_inh", {inh_ab_n, inh_cd_n}, 2'b10);
        host.step();
        chk("wave2", {ph, inh_ab_n, inh_cd_n}, {PAT[5], 2'b01});
        host.reset_pulse();
        host.mode(1'b1, 1'b1);
        // Overcurrent on the first pair only, chopped on the inhibit.
        sense_ab <= 8'hFF;
        repeat (8) @(posedge clk);
        watch(16);
        chk("inh_chop", cnt_a >= 12, 1'b1);
        chk("cd_free", cnt_b, 16);
        chop_tgt <= 1'b1;
        repeat (8) @(posedge clk);
        watch(16);
        chk("phase_chop", cnt_a >= 12, 1'b1);
        chk("cd_free2", cnt_b, 16);
        // Listener: no ticks until one is injected on the sync wire.
        chop_tgt <= 1'b0;
        osc_gnd <= 1'b1;
        repeat (20) @(posedge clk);
        chk("released", sync_oe_n, 1'b1);
        watch(24);
        chk("no_tick", cnt_a, 24);
        sync_in <= 1'b1;
        repeat (2) @(posedge clk);
        sync_in <= 1'b0;
        watch(10);
        chk("ext_tick", cnt_a < 10, 1'b1);
        enable <= 1'b0;
        repeat (5) @(posedge clk);
        chk("disabled", {ph, inh_ab_n, inh_cd_n}, 6'h00);
        sense_ab <= 8'h00;
        close_out();
    end

    // Ends a hang; a clean run takes under a thousand cycles.
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule // stepper_translator_chopper_tb

bind stc_top stc_monitor #(.SENSE_W(SENSE_W)) u_mon (.*);
